// ===== core/ts_codec_defines.svh
// Purpose: Named constants for the frame timestamp codec
// Assumes: Included by the package and the design modules
// Notes:   Bit 23 of a timestamp is the most significant level bit
`ifndef TS_CODEC_DEFINES_SVH
`define TS_CODEC_DEFINES_SVH

`define TS_W          24
`define TS_MSB        5'd23
`define TS_MAX        24'hf9ffff
`define TS_NULL       24'hffffff
`define TS_RSV_LO     24'hfa0000
`define TS_ZERO       24'h000000
`define TS_RFA_BYTE   8'hff

// Timebase: 16.384 MHz ticks from a 40 MHz clock by phase accumulation
`define CLK_KHZ       17'd40000
`define TB_KHZ        17'd16384
`define ACC_W         16
`define ACC_ZERO      16'h0000

// Level field positions, coarsest first
`define L1_HI 23
`define L1_LO 17
`define L2_HI 16
`define L2_LO 14
`define L3_HI 13
`define L3_LO 6
`define L4_HI 5
`define L4_LO 3
`define L5_HI 2
`define L5_LO 0

// Keep-masks per resolution level
`define MASK_L1       24'hfe0000
`define MASK_L2       24'hffc000
`define MASK_L3       24'hffffc0
`define MASK_L4       24'hfffff8
`define MASK_L5       24'hffffff

// Byte slots inside the four-byte frame field
`define POS_RFA       2'h0
`define POS_B0        2'h1
`define POS_B1        2'h2
`define POS_B2        2'h3

// Management byte coordinates of the last carried bit
`define MGMT_LAST_S   2'h2
`define MGMT_LAST_BL  3'h7

`endif

// ===== core/ts_codec_pkg.sv
// Purpose: Types shared by the timestamp codec
// Assumes: Constants come from the defines header
// Notes:   Whole codec state is one packed struct
`include "ts_codec_defines.svh"

package ts_codec_pkg;

  typedef logic [`TS_W-1:0] ts_t;

  typedef enum logic [2:0] {
    LVL_1 = 3'h1,
    LVL_2 = 3'h2,
    LVL_3 = 3'h3,
    LVL_4 = 3'h4,
    LVL_5 = 3'h5
  } level_t;

  typedef struct packed {
    logic [`ACC_W-1:0] acc;
    logic              tb_tick;
    ts_t               count;
    logic              locked;
    ts_t               tx_ts;
    logic [7:0]        tx_byte;
    logic              tx_mgmt_bit;
    ts_t               byte_sh;
    ts_t               mgmt_sh;
    ts_t               rx_ts;
    logic              rx_upd;
    logic              armed;
    logic              deliver;
  } codec_state_t;

endpackage

// ===== core/ts_classify.sv
// Purpose: Decode a timestamp into class flags and level fields
// Assumes: Pure combinational decode
// Notes:   Used on both the generated and the received value
`timescale 1ns/1ps
`include "ts_codec_defines.svh"

module ts_classify (
  input  wire ts_codec_pkg::ts_t ts,
  output logic                   is_null,
  output logic                   is_reserved,
  output logic                   is_valid,
  output logic [6:0]             lvl1,
  output logic [2:0]             lvl2,
  output logic [7:0]             lvl3,
  output logic [2:0]             lvl4,
  output logic [2:0]             lvl5
);
  import ts_codec_pkg::*;

  assign is_null     = (ts == `TS_NULL);
  assign is_reserved = (ts >= `TS_RSV_LO) && !is_null;
  assign is_valid    = (ts <= `TS_MAX);
  // Level split, coarsest first
  assign lvl1 = ts[`L1_HI:`L1_LO];
  assign lvl2 = ts[`L2_HI:`L2_LO];
  assign lvl3 = ts[`L3_HI:`L3_LO];
  assign lvl4 = ts[`L4_HI:`L4_LO];
  assign lvl5 = ts[`L5_HI:`L5_LO];

endmodule

// ===== core/frame_timestamp_codec.sv
// Purpose: Generate, insert, extract and check 24-bit frame timestamps
// Assumes: 40 MHz clk; all inputs but the async rst synchronous to clk
// Notes:   Timebase is a 16.384 MHz enable from a phase accumulator
`timescale 1ns/1ps
`include "ts_codec_defines.svh"

module frame_timestamp_codec (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ref_pulse,
  input  wire logic               frame_start,
  input  wire logic [2:0]         tx_level,
  input  wire logic [1:0]         tx_byte_pos,
  input  wire logic [1:0]         tx_mgmt_s,
  input  wire logic [2:0]         tx_mgmt_bl,
  input  wire logic               rx_byte_valid,
  input  wire logic [1:0]         rx_byte_pos,
  input  wire logic [7:0]         rx_byte,
  input  wire logic               rx_mgmt_valid,
  input  wire logic [1:0]         rx_mgmt_s,
  input  wire logic [2:0]         rx_mgmt_bl,
  input  wire logic               rx_mgmt_bit,
  output logic                    tb_tick,
  output logic                    ref_locked,
  output ts_codec_pkg::ts_t       tx_ts,
  output logic [7:0]              tx_ts_byte,
  output logic                    tx_mgmt_bit,
  output ts_codec_pkg::ts_t       rx_ts,
  output logic                    rx_ts_update,
  output logic                    rx_ts_valid,
  output logic                    rx_ts_null,
  output logic                    rx_ts_reserved,
  output logic [6:0]              rx_lvl1,
  output logic [2:0]              rx_lvl2,
  output logic [7:0]              rx_lvl3,
  output logic [2:0]              rx_lvl4,
  output logic [2:0]              rx_lvl5,
  output logic                    deliver_pulse
);
  import ts_codec_pkg::*;

  codec_state_t st_ff;
  codec_state_t nxt_st;

  ts_t          keep_mask;
  ts_t          tx_cand;
  logic         tx_cand_null;
  logic         tx_cand_rsv;
  logic         tx_cand_ok;
  logic         rx_is_null;
  logic         rx_is_rsv;
  logic         rx_is_ok;
  logic [16:0]  acc_sum;
  logic [4:0]   tx_idx;
  logic [4:0]   rx_idx;
  logic [4:0]   tx_bitpos;
  logic [4:0]   rx_bitpos;

  // Level keep-mask; out-of-range levels give full resolution
  always_comb begin
    unique case (tx_level)
      LVL_1:   keep_mask = `MASK_L1;
      LVL_2:   keep_mask = `MASK_L2;
      LVL_3:   keep_mask = `MASK_L3;
      LVL_4:   keep_mask = `MASK_L4;
      default: keep_mask = `MASK_L5;
    endcase
  end

  assign tx_cand   = st_ff.count & keep_mask;
  assign acc_sum   = {1'b0, st_ff.acc} + `TB_KHZ;
  assign tx_idx    = {tx_mgmt_s, tx_mgmt_bl};
  assign rx_idx    = {rx_mgmt_s, rx_mgmt_bl};
  assign tx_bitpos = `TS_MSB - tx_idx;
  assign rx_bitpos = `TS_MSB - rx_idx;

  ts_classify u_tx_chk (
    .ts          (tx_cand),
    .is_null     (tx_cand_null),
    .is_reserved (tx_cand_rsv),
    .is_valid    (tx_cand_ok),
    .lvl1        (),
    .lvl2        (),
    .lvl3        (),
    .lvl4        (),
    .lvl5        ()
  );

  ts_classify u_rx_chk (
    .ts          (st_ff.rx_ts),
    .is_null     (rx_is_null),
    .is_reserved (rx_is_rsv),
    .is_valid    (rx_is_ok),
    .lvl1        (rx_lvl1),
    .lvl2        (rx_lvl2),
    .lvl3        (rx_lvl3),
    .lvl4        (rx_lvl4),
    .lvl5        (rx_lvl5)
  );

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.tb_tick = 1'b0;
    nxt_st.rx_upd  = 1'b0;
    nxt_st.deliver = 1'b0;

    // Timebase enable at 16.384 MHz average rate
    if (acc_sum >= `CLK_KHZ) begin
      nxt_st.acc     = 16'(acc_sum - `CLK_KHZ);
      nxt_st.tb_tick = 1'b1;
    end else begin
      nxt_st.acc     = acc_sum[`ACC_W-1:0];
    end

    // Offset counter; a missed reference drops lock rather than wrap
    if (st_ff.tb_tick) begin
      if (st_ff.count == `TS_MAX) begin
        nxt_st.locked = 1'b0;
      end else begin
        nxt_st.count = st_ff.count + 24'h000001;
      end
    end
    if (ref_pulse) begin
      nxt_st.count   = `TS_ZERO;
      nxt_st.acc     = `ACC_ZERO;
      nxt_st.tb_tick = 1'b0;
      nxt_st.locked  = 1'b1;
    end

    // Latch at frame's first bit
    if (frame_start) begin
      if (!st_ff.locked || tx_cand_rsv || tx_cand_null || !tx_cand_ok) begin
        nxt_st.tx_ts = `TS_NULL;
      end else begin
        nxt_st.tx_ts = tx_cand;
      end
    end

    // Frame byte insertion
    unique case (tx_byte_pos)
      `POS_RFA: nxt_st.tx_byte = `TS_RFA_BYTE;
      `POS_B0:  nxt_st.tx_byte = st_ff.tx_ts[23:16];
      `POS_B1:  nxt_st.tx_byte = st_ff.tx_ts[15:8];
      `POS_B2:  nxt_st.tx_byte = st_ff.tx_ts[7:0];
    endcase

    // Management bit insertion; s beyond last carries nothing
    if (tx_mgmt_s <= `MGMT_LAST_S) begin
      nxt_st.tx_mgmt_bit = st_ff.tx_ts[tx_bitpos];
    end else begin
      nxt_st.tx_mgmt_bit = 1'b0;
    end

    // Frame byte extraction; reserved first byte is skipped
    if (rx_byte_valid) begin
      unique case (rx_byte_pos)
        `POS_RFA: nxt_st.byte_sh = st_ff.byte_sh;
        `POS_B0:  nxt_st.byte_sh[23:16] = rx_byte;
        `POS_B1:  nxt_st.byte_sh[15:8] = rx_byte;
        `POS_B2: begin
          nxt_st.rx_ts  = {st_ff.byte_sh[23:8], rx_byte};
          nxt_st.rx_upd = 1'b1;
          nxt_st.armed  = 1'b1;
        end
      endcase
    end

    // Management bit extraction
    if (rx_mgmt_valid && (rx_mgmt_s <= `MGMT_LAST_S)) begin
      nxt_st.mgmt_sh[rx_bitpos] = rx_mgmt_bit;
      if ((rx_mgmt_s == `MGMT_LAST_S) && (rx_mgmt_bl == `MGMT_LAST_BL)) begin
        nxt_st.rx_ts     = st_ff.mgmt_sh;
        nxt_st.rx_ts[0]  = rx_mgmt_bit;
        nxt_st.rx_upd    = 1'b1;
        nxt_st.armed     = 1'b1;
      end
    end

    // Delivery when local offset reaches received time
    if (st_ff.armed && !st_ff.rx_upd && st_ff.locked && rx_is_ok && st_ff.tb_tick &&
        (st_ff.count == st_ff.rx_ts)) begin
      nxt_st.deliver = 1'b1;
      nxt_st.armed   = nxt_st.rx_upd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tb_tick        = st_ff.tb_tick;
  assign ref_locked     = st_ff.locked;
  assign tx_ts          = st_ff.tx_ts;
  assign tx_ts_byte     = st_ff.tx_byte;
  assign tx_mgmt_bit    = st_ff.tx_mgmt_bit;
  assign rx_ts          = st_ff.rx_ts;
  assign rx_ts_update   = st_ff.rx_upd;
  assign rx_ts_valid    = rx_is_ok;
  assign rx_ts_null     = rx_is_null;
  assign rx_ts_reserved = rx_is_rsv;
  assign deliver_pulse  = st_ff.deliver;

endmodule

// ===== sim/frame_timestamp_codec_properties.sv
// Purpose: Port-level properties of the timestamp codec
// Assumes: One clock, async active-high reset
// Notes:   Bound to every codec instance
`timescale 1ns/1ps
module frame_timestamp_codec_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ref_pulse,
  input wire logic        frame_start,
  input wire logic [1:0]  tx_byte_pos,
  input wire logic [1:0]  tx_mgmt_s,
  input wire logic [2:0]  tx_mgmt_bl,
  input wire logic        ref_locked,
  input wire logic [23:0] tx_ts,
  input wire logic [7:0]  tx_ts_byte,
  input wire logic        tx_mgmt_bit,
  input wire logic [23:0] rx_ts,
  input wire logic        rx_ts_null,
  input wire logic        rx_ts_reserved,
  input wire logic        deliver_pulse
);
  logic [23:0] ts_ff;
  logic [4:0]  idx_ff;
  // Last cycle's timestamp and carried bit index
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_ff  <= 24'h0;
      idx_ff <= 5'h0;
    end else begin
      ts_ff  <= tx_ts;
      idx_ff <= 5'h17 - {tx_mgmt_s, 3'h0} - {2'h0, tx_mgmt_bl};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_dead_frame;
    frame_start && !ref_locked;
  endsequence
  sequence s_clean_rx;
    !rx_ts_null && !rx_ts_reserved;
  endsequence
  a_null_unlocked: assert property (s_dead_frame |=> tx_ts == 24'hffffff)
    else $error("no null while unlocked");
  a_no_reserved: assert property (tx_ts <= 24'hf9ffff || tx_ts == 24'hffffff)
    else $error("reserved value sent");
  a_rfa_byte: assert property (tx_byte_pos == 2'h0 |=> tx_ts_byte == 8'hff)
    else $error("first byte not ff");
  a_byte_msb: assert property (tx_byte_pos == 2'h1 |=> tx_ts_byte == ts_ff[23:16])
    else $error("byte order");
  a_mgmt_map: assert property (tx_mgmt_s != 2'h3 |=> tx_mgmt_bit == ts_ff[idx_ff])
    else $error("mgmt bit map");
  a_mgmt_idle: assert property (tx_mgmt_s == 2'h3 |=> !tx_mgmt_bit)
    else $error("mgmt bit outside map");
  a_ref_lock: assert property (ref_pulse |=> ref_locked)
    else $error("no lock after reference");
  a_rx_class: assert property (rx_ts_reserved == (rx_ts >= 24'hfa0000 && rx_ts != 24'hffffff))
    else $error("reserved flag");
  a_rx_null: assert property (rx_ts_null == (rx_ts == 24'hffffff))
    else $error("null flag");
  a_deliver_ok: assert property (deliver_pulse |-> s_clean_rx ##1 !deliver_pulse)
    else $error("bad delivery");
endmodule
bind frame_timestamp_codec frame_timestamp_codec_properties chk (.clk, .rst, .ref_pulse, .frame_start, .tx_byte_pos,
  .tx_mgmt_s, .tx_mgmt_bl, .ref_locked, .tx_ts, .tx_ts_byte, .tx_mgmt_bit, .rx_ts, .rx_ts_null, .rx_ts_reserved,
  .deliver_pulse);

// ===== sim/ts_time_ref.sv
// Purpose: Time reference and frame sync source
// Assumes: Pulses start 1 ns after a rising edge
// Notes:   One reference feeds latch and delivery
`timescale 1ns/1ps
module ts_time_ref (
  input  wire logic clk,
  output logic      ref_pulse,
  output logic      frame_start
);
  initial {ref_pulse, frame_start} = 2'h0;
  // Reference point or frame start, one cycle wide
  task automatic fire(input logic is_ref);
    @(posedge clk);
    #1 {ref_pulse, frame_start} = is_ref ? 2'h2 : 2'h1;
    @(posedge clk);
    #1 {ref_pulse, frame_start} = 2'h0;
  endtask
endmodule

// ===== sim/frame_timestamp_codec_tb.sv
// Purpose: Self-checking bench for the timestamp codec
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Count figures allow a few ticks of slack
`timescale 1ns/1ps
module frame_timestamp_codec_tb;
  import ts_codec_pkg::*;
  logic       clk = 1'b0;
  logic       rst, ref_pulse, frame_start, rx_byte_valid, rx_mgmt_valid, rx_mgmt_bit;
  logic       ref_locked, tx_mgmt_bit, rx_ts_valid, rx_ts_null, rx_ts_reserved, deliver_pulse;
  logic       tb_tick, rx_ts_update;
  logic [2:0] tx_level, tx_mgmt_bl, rx_mgmt_bl, rx_lvl2, rx_lvl4, rx_lvl5;
  logic [1:0] tx_byte_pos, tx_mgmt_s, rx_byte_pos, rx_mgmt_s;
  logic [7:0] rx_byte, tx_ts_byte, rx_lvl3;
  logic [6:0] rx_lvl1;
  ts_t        tx_ts, rx_ts;
  int         mismatches = 0;
  int         n_checks = 0;
  int         cyc = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc++;
  ts_time_ref src (.clk, .ref_pulse, .frame_start);
  frame_timestamp_codec dut (.clk, .rst, .ref_pulse, .frame_start, .tx_level, .tx_byte_pos, .tx_mgmt_s, .tx_mgmt_bl,
    .rx_byte_valid, .rx_byte_pos, .rx_byte, .rx_mgmt_valid, .rx_mgmt_s, .rx_mgmt_bl, .rx_mgmt_bit, .tb_tick,
    .ref_locked, .tx_ts, .tx_ts_byte, .tx_mgmt_bit, .rx_ts, .rx_ts_update, .rx_ts_valid, .rx_ts_null,
    .rx_ts_reserved, .rx_lvl1, .rx_lvl2, .rx_lvl3, .rx_lvl4, .rx_lvl5, .deliver_pulse);
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic err(input string m);
    mismatches++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk(input ts_t got, input ts_t exp, input string m);
    n_checks++;
    if (got !== exp) err(m);
  endtask
  task automatic tx_fields(input ts_t e);
    for (int p = 0; p < 4; p++) begin
      tx_byte_pos = 2'(p);
      step();
      chk({16'h0, tx_ts_byte}, {16'h0, 8'({8'hff, e} >> (24 - 8 * p))}, "byte");
    end
    for (int i = 0; i < 24; i++) begin
      tx_mgmt_s = 2'(i / 8);
      tx_mgmt_bl = 3'(i % 8);
      step();
      chk({23'h0, tx_mgmt_bit}, {23'h0, e[23 - i]}, "mgmt");
    end
    tx_mgmt_s = 2'h3;
    step();
    chk({23'h0, tx_mgmt_bit}, 24'h0, "mgmt idle");
  endtask
  task automatic rx_send(input ts_t v);
    rx_byte_valid = 1'b1;
    for (int p = 0; p < 4; p++) begin
      rx_byte_pos = 2'(p);
      rx_byte = 8'({8'hff, v} >> (24 - 8 * p));
      step();
    end
    chk({23'h0, rx_ts_update}, 24'h1, "rx update");
    rx_byte_valid = 1'b0;
    step();
    chk({23'h0, rx_ts_update}, 24'h0, "rx update end");
  endtask
  task automatic t_tx();
    int t0;
    int e;
    int ticks = 0;
    tx_level = 3'h2;
    src.fire(1'b0);
    chk(tx_ts, 24'hffffff, "unlocked");
    chk({23'h0, ref_locked}, 24'h0, "lock at start");
    tx_fields(24'hffffff);
    src.fire(1'b1);
    t0 = cyc;
    chk({23'h0, ref_locked}, 24'h1, "lock");
    repeat (1000) begin
      step();
      if (tb_tick === 1'b1) ticks++;
    end
    n_checks++;
    if (ticks < 409 || ticks > 410) err("tick rate");
    tx_level = 3'h3;
    src.fire(1'b0);
    chk(tx_ts, 24'h000180, "level 3");
    tx_fields(24'h000180);
    tx_level = 3'h1;
    src.fire(1'b0);
    chk(tx_ts, 24'h0, "level 1");
    tx_level = 3'h4;
    src.fire(1'b0);
    chk(tx_ts & 24'h000007, 24'h0, "level 4");
    tx_level = 3'h5;
    src.fire(1'b0);
    e = (cyc - t0) * 16384 / 40000;
    n_checks++;
    if ((tx_ts <= 24'(e + 3) && tx_ts >= 24'(e - 3)) !== 1'b1) err("count");
  endtask
  task automatic t_rx();
    ts_t v[6] = '{24'h0, 24'hf9ffff, 24'hfa0000, 24'hfffffe, 24'hffffff, 24'h5a3c81};
    ts_t m = 24'ha5c3e1;
    ts_t c;
    foreach (v[i]) begin
      rx_send(v[i]);
      c = {21'h0, v[i] <= 24'hf9ffff, v[i] == 24'hffffff, v[i] > 24'hf9ffff && v[i] != 24'hffffff};
      chk(rx_ts, v[i], "rx bytes");
      chk({21'h0, rx_ts_valid, rx_ts_null, rx_ts_reserved}, c, "class");
      chk({rx_lvl1, rx_lvl2, rx_lvl3, rx_lvl4, rx_lvl5}, v[i], "levels");
    end
    rx_mgmt_valid = 1'b1;
    for (int i = 0; i < 24; i++) begin
      rx_mgmt_s = 2'(i / 8);
      rx_mgmt_bl = 3'(i % 8);
      rx_mgmt_bit = m[23 - i];
      step();
    end
    chk({23'h0, rx_ts_update}, 24'h1, "mgmt update");
    rx_mgmt_valid = 1'b0;
    step();
    chk(rx_ts, m, "rx mgmt");
    rx_mgmt_valid = 1'b1;
    rx_mgmt_s = 2'h3;
    rx_mgmt_bl = 3'h7;
    rx_mgmt_bit = ~m[0];
    step();
    chk({23'h0, rx_ts_update}, 24'h0, "mgmt idle update");
    rx_mgmt_valid = 1'b0;
    step();
    chk(rx_ts, m, "mgmt idle");
  endtask
  task automatic t_deliver();
    int t0;
    int d = 0;
    int hits = 0;
    src.fire(1'b1);
    t0 = cyc;
    rx_send(24'd200);
    repeat (1200) begin
      step();
      if (deliver_pulse !== 1'b0) begin
        hits++;
        d = cyc - t0;
      end
    end
    n_checks++;
    if (hits != 1 || d < 485 || d > 495) err("delivery");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {tx_level, tx_byte_pos, tx_mgmt_s, tx_mgmt_bl, rx_byte_valid, rx_byte_pos, rx_byte} = '0;
    {rx_mgmt_valid, rx_mgmt_s, rx_mgmt_bl, rx_mgmt_bit} = '0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_tx();
    t_rx();
    t_deliver();
    results();
  end
  initial begin
    #300000;
    mismatches++;
    results();
  end
endmodule
